// *** bench/crp_host_model.sv ***
// Host model: issues single-byte commands on the strobe register bus.
// Assumes the device answers a read exactly one cycle after the strobe.
`timescale 1ns/1ps
module crp_host_model
  import crp_pkg::*;
(
  // Clock
  input  wire logic              mclk,
  // Requests
  output logic                   regWrEn,
  output logic                   regRdEn,
  output logic [CMD_W-1:0]       regCmd,
  output logic [DATA_W-1:0]      regWrData,
  // Answers
  input  wire logic [DATA_W-1:0] regRdData,
  input  wire logic              regRdValid,
  input  wire logic              remapRejected,
  output logic                   hang
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regCmd = 8'h00;
    regWrData = 8'h00;
    hang = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Released lines show the inverse so a stale value is never mistaken for data
  task automatic wr(input logic [7:0] c, input logic [7:0] d, output logic rej);
    @(negedge mclk);
    regCmd = c;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge mclk);
    rej = remapRejected;
    regWrEn = 1'b0;
    regCmd = ~c;
    regWrData = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    @(negedge mclk);
    regCmd = c;
    regRdEn = 1'b1;
    @(negedge mclk);
    regRdEn = 1'b0;
    regCmd = ~c;
    d = regRdData;
    if (regRdValid !== 1'b1) begin
      hang = 1'b1;
    end
  endtask : rd
endmodule : crp_host_model

// *** bench/crp_regs_test.sv ***
// Testbench for the remap and shutdown priority registers.
// Assumes the upper group (GROUP = 1) so the group bit shows on the mapping.
`timescale 1ns/1ps
module crp_regs_test;
  import crp_pkg::*;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        extResetN = 1'b1;
  logic        regWrEn, regRdEn, regRdValid, remapRejected, hostHang;
  logic [7:0]  regCmd, regWrData, regRdData, shutdownPriorityLevel;
  logic [3:0]  chanIsOff = 4'hF;
  logic        threeBitPrioritySelect = 1'b0;
  logic        fastShutdownValid = 1'b0;
  logic [2:0]  fastShutdownCode = 3'h0;
  logic [1:0]  prioTurnOff;
  logic [11:0] physChan;
  int          num_errors = 0;
  int          num_checks = 0;

  always #12.5 mclk = ~mclk;

  crp_regs #(.GROUP(1'b1)) u_dut (.mclk(mclk), .rstn(rstn), .extResetN(extResetN),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regCmd(regCmd), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .remapRejected(remapRejected),
    .chanIsOff(chanIsOff), .threeBitPrioritySelect(threeBitPrioritySelect),
    .fastShutdownValid(fastShutdownValid), .fastShutdownCode(fastShutdownCode),
    .prioTurnOff(prioTurnOff), .physChan(physChan),
    .shutdownPriorityLevel(shutdownPriorityLevel));

  crp_host_model u_host (.mclk(mclk), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regCmd(regCmd), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .remapRejected(remapRejected), .hang(hostHang));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic w(input logic [7:0] c, input logic [7:0] d, input logic expRej);
    logic rej;
    u_host.wr(c, d, rej);
    chk(rej, expRej);
  endtask : w

  task automatic r(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(c, d);
    chk(d, exp);
  endtask : r

  task automatic sd(input logic [2:0] c, input logic sel, input logic [1:0] exp);
    @(negedge mclk);
    fastShutdownCode = c;
    fastShutdownValid = 1'b1;
    threeBitPrioritySelect = sel;
    @(negedge mclk);
    fastShutdownValid = 1'b0;
    chk(prioTurnOff, exp);
  endtask : sd

  // A read with no answer would leave the run waiting for nothing
  always @(posedge hostHang) begin
    num_errors++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    r(CMD_REMAP, REMAP_RST);
    r(CMD_PRIO12, PRIO_RST);
    r(8'h55, RD_NONE);
    chk(physChan, 12'hFAC);
    chanIsOff = 4'h7;
    w(CMD_REMAP, 8'h1B, 1'b1);
    chanIsOff = 4'hF;
    w(CMD_REMAP, 8'h00, 1'b1);
    r(CMD_REMAP, REMAP_RST);
    w(CMD_REMAP, 8'h1B, 1'b0);
    chk(physChan, 12'h977);
    w(CMD_PRIO12, 8'hFF, 1'b0);
    r(CMD_PRIO12, PRIO_MASK);
    w(CMD_PRIO12, 8'h25, 1'b0);
    chk(shutdownPriorityLevel, 8'h25);
    for (int c = 0; c < 8; c++) begin
      sd(3'(c), 1'b1, {c <= 2, c <= 5});
    end
    sd(3'h0, 1'b0, 2'b00);
    extResetN = 1'b0;
    w(CMD_REMAP, 8'hE4, 1'b1);
    extResetN = 1'b1;
    r(CMD_PRIO12, PRIO_RST);
    r(CMD_REMAP, 8'h1B);
    rstn = 1'b0;
    @(negedge mclk);
    rstn = 1'b1;
    r(CMD_REMAP, REMAP_RST);
    give_verdict();
  end
endmodule : crp_regs_test

// *** verilog/crp_pkg.sv ***
// Package for the channel remap and shutdown priority registers.
// Assumes command codes arrive already decoded from the serial management bus.
package crp_pkg;

  localparam int         CMD_W       = 8;
  localparam int         DATA_W      = 8;
  localparam int         NUM_LOG     = 4;
  localparam int         MAP_FW      = 2;
  localparam int         PRIO_W      = 3;
  localparam int         PRIO_CH     = 2;
  localparam int         PHYS_W      = MAP_FW + 1;

  // Command codes
  localparam logic [7:0] CMD_REMAP   = 8'h26;
  localparam logic [7:0] CMD_PRIO12  = 8'h27;

  // Reset values
  localparam logic [7:0] REMAP_RST   = 8'hE4;
  localparam logic [7:0] PRIO_RST    = 8'h00;
  localparam logic [7:0] RD_NONE     = 8'h00;

  // Priority field layout; bits 7 and 3 are unused and read zero
  localparam int         PRIO_CH1_LSB = 0;
  localparam int         PRIO_CH2_LSB = 4;
  localparam logic [7:0] PRIO_MASK   = 8'h77;

  // True when the four two-bit codes are all different
  function automatic logic crp_is_perm(input logic [7:0] m);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < NUM_LOG; i++) begin
      for (int j = i + 1; j < NUM_LOG; j++) begin
        if (m[i*MAP_FW +: MAP_FW] == m[j*MAP_FW +: MAP_FW]) begin
          ok = 1'b0;
        end
      end
    end
    return ok;
  endfunction : crp_is_perm

endpackage : crp_pkg

// *** verilog/crp_regs.sv ***
// Channel remap and shutdown priority registers of the eight-channel controller.
// Assumes command decode of the serial bus upstream; all inputs synchronous to mclk.
`timescale 1ns/1ps
module crp_regs
  import crp_pkg::*;
#(
  parameter logic GROUP = 1'b0
)(
  // Clock and resets
  input  wire logic                mclk,
  input  wire logic                rstn,
  input  wire logic                extResetN,
  // Register access
  input  wire logic                regWrEn,
  input  wire logic                regRdEn,
  input  wire logic [CMD_W-1:0]    regCmd,
  input  wire logic [DATA_W-1:0]   regWrData,
  output logic      [DATA_W-1:0]   regRdData,
  output logic                     regRdValid,
  output logic                     remapRejected,
  // Channel state of the group
  input  wire logic [NUM_LOG-1:0]  chanIsOff,
  // Fast shutdown
  input  wire logic                threeBitPrioritySelect,
  input  wire logic                fastShutdownValid,
  input  wire logic [PRIO_W-1:0]   fastShutdownCode,
  output logic      [PRIO_CH-1:0]  prioTurnOff,
  // Mapping out
  output logic [NUM_LOG*PHYS_W-1:0] physChan,
  output logic [DATA_W-1:0]        shutdownPriorityLevel
);

  crp_remap_if rif ();

  logic [DATA_W-1:0]  prio_q;
  logic [DATA_W-1:0]  rdData_q;
  logic               rdValid_q;
  logic [PRIO_CH-1:0] turnOff_q;

  ////////////////////////////////////////////////////////////////////////////
  // Remap store
  assign rif.wrStb    = regWrEn && (regCmd == CMD_REMAP);
  assign rif.wrData   = regWrData;
  assign rif.groupOff = &chanIsOff;
  // Writes are not taken while the device sits in pin reset
  assign rif.holdN    = extResetN;

  crp_remap_reg u_remap (
    .mclk (mclk),
    .rstn (rstn),
    .rif  (rif)
  );

  assign remapRejected = rif.rejected;

  // group bit fixed, field order, code to channel
  genvar g;
  generate
    for (g = 0; g < NUM_LOG; g++) begin : g_map
      assign physChan[g*PHYS_W +: PHYS_W] = {GROUP, rif.mapQ[g*MAP_FW +: MAP_FW]};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // priority byte, cleared by either reset
  always_ff @(posedge mclk) begin
    if (!rstn || !extResetN) begin
      prio_q <= PRIO_RST;
    end else if (regWrEn && (regCmd == CMD_PRIO12)) begin
      prio_q <= regWrData & PRIO_MASK;
    end
  end

  assign shutdownPriorityLevel = prio_q;

  // Read port: one cycle of latency, unknown codes read zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdData_q  <= RD_NONE;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= regRdEn;
      if (regRdEn) begin
        unique case (regCmd)
          CMD_REMAP:  rdData_q <= rif.mapQ;
          CMD_PRIO12: rdData_q <= prio_q;
          default:    rdData_q <= RD_NONE;
        endcase
      end
    end
  end

  assign regRdData  = rdData_q;
  assign regRdValid = rdValid_q;

  ////////////////////////////////////////////////////////////////////////////
  // code compare per channel; pulse only, cool-down untouched
  // The off request is a separate pulse so the channel logic can skip the
  // cool-down cancel that a normal reset command would do.
  always_ff @(posedge mclk) begin
    if (!rstn || !extResetN) begin
      turnOff_q <= '0;
    end else begin
      turnOff_q[0] <= fastShutdownValid && threeBitPrioritySelect &&
                      (fastShutdownCode <= prio_q[PRIO_CH1_LSB +: PRIO_W]);
      turnOff_q[1] <= fastShutdownValid && threeBitPrioritySelect &&
                      (fastShutdownCode <= prio_q[PRIO_CH2_LSB +: PRIO_W]);
    end
  end

  assign prioTurnOff = turnOff_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_remapRst;
    @(posedge mclk) disable iff (1'b0) !rstn |=> (rif.mapQ == REMAP_RST);
  endproperty
  a_remapRst: assert property (p_remapRst) else $error("remap not identity after reset");

  property p_offGate;
    (rif.wrStb && !(&chanIsOff)) |=> $stable(rif.mapQ) && remapRejected;
  endproperty
  a_offGate: assert property (p_offGate) else $error("remap taken while group on");

  property p_dupReject;
    (rif.wrStb && !crp_is_perm(regWrData)) |=> $stable(rif.mapQ) && remapRejected;
  endproperty
  a_dupReject: assert property (p_dupReject) else $error("duplicate remap taken");

  property p_accept;
    (rif.wrStb && extResetN && (&chanIsOff) && crp_is_perm(regWrData))
      |=> (rif.mapQ == $past(regWrData)) && !remapRejected;
  endproperty
  a_accept: assert property (p_accept) else $error("valid remap not stored");

  property p_extKeep;
    !extResetN |=> $stable(rif.mapQ);
  endproperty
  a_extKeep: assert property (p_extKeep) else $error("pin reset changed remap");

  property p_group;
    physChan[NUM_LOG*PHYS_W-1] == GROUP && physChan[PHYS_W-1] == GROUP &&
      physChan[MAP_FW-1:0] == rif.mapQ[MAP_FW-1:0];
  endproperty
  a_group: assert property (p_group) else $error("physical channel left group");

  property p_prioRead;
    (regRdEn && regCmd == CMD_PRIO12) |=> regRdValid &&
      (regRdData == $past(prio_q)) && ((regRdData & ~PRIO_MASK) == RD_NONE);
  endproperty
  a_prioRead: assert property (p_prioRead) else $error("priority read wrong");

  property p_prioExtRst;
    !extResetN |=> (prio_q == PRIO_RST) && (prioTurnOff == '0);
  endproperty
  a_prioExtRst: assert property (p_prioExtRst) else $error("priority not cleared");

  property p_shutOff;
    (extResetN && fastShutdownValid && threeBitPrioritySelect &&
      fastShutdownCode <= prio_q[PRIO_CH2_LSB +: PRIO_W]) |=> prioTurnOff[1];
  endproperty
  a_shutOff: assert property (p_shutOff) else $error("channel two not turned off");

  property p_shutKeep;
    (fastShutdownValid && fastShutdownCode > prio_q[PRIO_CH1_LSB +: PRIO_W])
      |=> !prioTurnOff[0];
  endproperty
  a_shutKeep: assert property (p_shutKeep) else $error("channel one off on higher code");

  property p_shutOff1;
    (extResetN && fastShutdownValid && threeBitPrioritySelect &&
      fastShutdownCode <= prio_q[PRIO_CH1_LSB +: PRIO_W]) |=> prioTurnOff[0];
  endproperty
  a_shutOff1: assert property (p_shutOff1) else $error("channel one not turned off");

  property p_shutKeep2;
    (fastShutdownValid && fastShutdownCode > prio_q[PRIO_CH2_LSB +: PRIO_W])
      |=> !prioTurnOff[1];
  endproperty
  a_shutKeep2: assert property (p_shutKeep2) else $error("channel two off on higher code");

  // Turn-off only when the three-bit scheme is selected
  property p_noSelect;
    !threeBitPrioritySelect |=> (prioTurnOff == '0);
  endproperty
  a_noSelect: assert property (p_noSelect) else $error("turn-off without select");

  property p_prioWrite;
    (regWrEn && regCmd == CMD_PRIO12 && extResetN)
      |=> (prio_q == ($past(regWrData) & PRIO_MASK));
  endproperty
  a_prioWrite: assert property (p_prioWrite) else $error("priority write not stored");

  property p_rdValidOnly;
    !regRdEn |=> !regRdValid;
  endproperty
  a_rdValidOnly: assert property (p_rdValidOnly) else $error("read valid without read");

  property p_unknownRd;
    (regRdEn && regCmd != CMD_REMAP && regCmd != CMD_PRIO12) |=> (regRdData == RD_NONE);
  endproperty
  a_unknownRd: assert property (p_unknownRd) else $error("unknown code read nonzero");

  property p_remapRead;
    (regRdEn && regCmd == CMD_REMAP) |=> regRdValid && (regRdData == $past(rif.mapQ));
  endproperty
  a_remapRead: assert property (p_remapRead) else $error("remap read wrong");

  // A reject pulse must come from a remap write only
  property p_rejOnly;
    !rif.wrStb |=> !remapRejected;
  endproperty
  a_rejOnly: assert property (p_rejOnly) else $error("reject without remap write");

endmodule : crp_regs

// *** verilog/crp_remap_if.sv ***
// Link between the command decoder and the remap store.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface crp_remap_if;
  import crp_pkg::*;
  logic              wrStb;
  logic [DATA_W-1:0] wrData;
  logic              groupOff;
  logic              holdN;
  logic [DATA_W-1:0] mapQ;
  logic              rejected;

  modport ctrl  (output wrStb, wrData, groupOff, holdN, input mapQ, rejected);
  modport store (input wrStb, wrData, groupOff, holdN, output mapQ, rejected);
endinterface : crp_remap_if

// *** verilog/crp_remap_reg.sv ***
// Remap store: holds the logical-to-physical mapping of one group of four.
// Assumes rstn is the power-on reset; the external reset pin arrives as holdN.
`timescale 1ns/1ps
module crp_remap_reg
  import crp_pkg::*;
(
  // Clock and power-on reset
  input  wire logic  mclk,
  input  wire logic  rstn,
  // Command side
  crp_remap_if.store rif
);

  logic [DATA_W-1:0] mapQ_q;
  logic              rej_q;
  logic              take;

  ////////////////////////////////////////////////////////////////////////////
  // all-off gate, duplicate reject
  assign take = rif.wrStb && rif.holdN && rif.groupOff && crp_is_perm(rif.wrData);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mapQ_q <= REMAP_RST;
    end else if (take) begin
      mapQ_q <= rif.wrData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rej_q <= 1'b0;
    end else begin
      rej_q <= rif.wrStb && !take;
    end
  end

  assign rif.mapQ     = mapQ_q;
  assign rif.rejected = rej_q;

endmodule : crp_remap_reg
